// [design/gcin_top.sv]
/*
 * Gate controller core: input handling, movement sequencing, fault code,
 * status relays and keypad LEDs, with a classic Wishbone register slave.
 * Assumes pins and plant status arrive asynchronously; DIP switches are static.
 */
`timescale 1ns/1ns
`include "gcin_consts.svh"

// What this block does
// - Encoder link loss shows link fault code
// - Travel timeout stops, shows code, command clears
// - Direction fault: keypad only, after relock
// - Memory inconsistency flagged, cleared by restart
// - Encoder checksum failure shows checksum code
// - Passed safety end shows its code
// - Missing or bad calibration shows code
// - Inputs active when tied to +24V
// - Step input advances stop/up/stop/down sequence
// - Pull opens, closes after hold if safe
// - Emergency in alarm opens mid1, alarm-closes
// - Upper sensor stops closing, except alarm closing
// - Reset input restarts; lock clears detector alarm
// - Relays for mains, battery, safety ends, brake
// - Relays for mid1, opened, closed positions
// - Smoke trip opens to smoke position, recloses
// - Activity LED steady when active, flashes moving
// - Edge LED flashes on trip or absence
// - Sensor LED flashes on trip or absence
// - One flash lower, two upper, alternate
module gcin_top #(
    parameter int unsigned SEC_CYCLES = `GCIN_SEC_NS / `GCIN_CLK_PERIOD_NS,
    parameter int unsigned BLINK_CYCLES = `GCIN_BLINK_NS / `GCIN_CLK_PERIOD_NS
) (
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [3:0] WB_SEL_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire gcin_pkg::gcin_pins_s PINS,
    input wire gcin_pkg::gcin_plant_s PLANT,
    input wire logic [8:1] DIP,
    output gcin_pkg::gcin_out_s OUTS
);
    import gcin_pkg::*;

    if (SEC_CYCLES < 2 || BLINK_CYCLES < 2) begin : g_bad_ticks
        $error("gcin_top: tick periods must be at least 2 cycles");
    end

    localparam int PW = $bits(gcin_pins_s) + $bits(gcin_plant_s);

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers and edges
    logic [PW-1:0] sync1_ff, sync2_ff, prev_ff;
    logic [8:1] dip1_ff, dip_ff;
    gcin_pins_s pn, pp;
    gcin_plant_s pl;

    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            prev_ff <= '0;
            dip1_ff <= '0;
            dip_ff <= '0;
        end else begin
            sync1_ff <= {PINS, PLANT};
            sync2_ff <= sync1_ff;
            prev_ff <= sync2_ff;
            dip1_ff <= DIP;
            dip_ff <= dip1_ff;
        end
    end

    always_comb begin
        {pn, pl} = sync2_ff;
        pp = gcin_pins_s'(prev_ff[PW-1 -: $bits(gcin_pins_s)]);
    end

    // High level means the contact is tied to +24 V
    gcin_pins_s rise;
    assign rise = pn & ~pp;

    ////////////////////////////////////////////////////////////////////////
    // Second and blink ticks
    logic [31:0] sec_cnt_ff, nxt_sec_cnt, blk_cnt_ff, nxt_blk_cnt;
    logic blink_ff, nxt_blink, sec_tick, blk_tick;

    always_comb begin
        sec_tick = (sec_cnt_ff == 32'(SEC_CYCLES - 1));
        blk_tick = (blk_cnt_ff == 32'(BLINK_CYCLES - 1));
        nxt_sec_cnt = sec_tick ? 32'h0 : sec_cnt_ff + 32'h1;
        nxt_blk_cnt = blk_tick ? 32'h0 : blk_cnt_ff + 32'h1;
        nxt_blink = blk_tick ? ~blink_ff : blink_ff;
    end

    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sec_cnt_ff <= '0;
            blk_cnt_ff <= '0;
            blink_ff <= 1'b0;
        end else begin
            sec_cnt_ff <= nxt_sec_cnt;
            blk_cnt_ff <= nxt_blk_cnt;
            blink_ff <= nxt_blink;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wishbone register slave
    logic [7:0] hold_ff, nxt_hold, emerg_ff, nxt_emerg, smoke_ff, nxt_smoke;
    logic enable_ff, nxt_enable, ack_ff, nxt_ack;
    logic [31:0] rdat_ff, nxt_rdat, status;
    logic wr;
    gcin_state_e st_ff;
    gcin_fault_e fault;
    logic dir_lock_ff, smoke_alarm_ff;

    always_comb begin
        status = '0;
        status[`GCIN_ST_FAULT_LSB +: 3] = fault;
        status[`GCIN_ST_STATE_LSB +: 4] = st_ff;
        status[`GCIN_ST_DIRLOCK] = dir_lock_ff;
        status[`GCIN_ST_SMOKEALM] = smoke_alarm_ff;
        nxt_ack = WB_CYC_I & WB_STB_I & ~ack_ff;
        wr = nxt_ack & WB_WE_I & WB_SEL_I[0];
        nxt_hold = hold_ff;
        nxt_emerg = emerg_ff;
        nxt_smoke = smoke_ff;
        nxt_enable = enable_ff;
        if (wr) begin
            case (WB_ADR_I)
                `GCIN_REG_HOLD: nxt_hold = WB_DAT_I[7:0];
                `GCIN_REG_EMERG: nxt_emerg = WB_DAT_I[7:0];
                `GCIN_REG_SMOKE: nxt_smoke = WB_DAT_I[7:0];
                `GCIN_REG_CTRL: nxt_enable = WB_DAT_I[`GCIN_CTRL_ENABLE];
                default: nxt_hold = hold_ff;
            endcase
        end
        case (WB_ADR_I)
            `GCIN_REG_HOLD: nxt_rdat = {24'h0, hold_ff};
            `GCIN_REG_EMERG: nxt_rdat = {24'h0, emerg_ff};
            `GCIN_REG_SMOKE: nxt_rdat = {24'h0, smoke_ff};
            `GCIN_REG_CTRL: nxt_rdat = {31'h0, enable_ff};
            `GCIN_REG_STATUS: nxt_rdat = status;
            default: nxt_rdat = 32'h0;
        endcase
        if (!nxt_ack) begin
            nxt_rdat = 32'h0;
        end
    end

    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            hold_ff <= `GCIN_HOLD_RST;
            emerg_ff <= `GCIN_EMERG_RST;
            smoke_ff <= `GCIN_SMOKE_RST;
            enable_ff <= `GCIN_CTRL_RST;
            ack_ff <= 1'b0;
            rdat_ff <= '0;
        end else begin
            hold_ff <= nxt_hold;
            emerg_ff <= nxt_emerg;
            smoke_ff <= nxt_smoke;
            enable_ff <= nxt_enable;
            ack_ff <= nxt_ack;
            rdat_ff <= nxt_rdat;
        end
    end

    assign WB_ACK_O = ack_ff;
    assign WB_DAT_O = rdat_ff;

    ////////////////////////////////////////////////////////////////////////
    // Movement sequencer and faults
    gcin_state_e nxt_st;
    gcin_target_e tgt_ff, nxt_tgt;
    logic [7:0] tmr_ff, nxt_tmr, wait_ff, nxt_wait;
    logic last_up_ff, nxt_last_up, aclose_ff, nxt_aclose;
    logic tout_ff, nxt_tout, nxt_dir_lock, nvm_ff, nxt_nvm;
    logic relock_ff, nxt_relock, nxt_smoke_alarm, c_pull_pend_ff;
    logic ext_ok, key_ok, fire, reached, safe_close, restart;
    logic c_open, c_close, c_stop, c_step, c_pull, c_emerg, c_smoke, c_move;

    always_comb begin
        fire = ~pn.fire_alarm_nc;
        restart = rise.reset_in;
        ext_ok = enable_ff & ~dir_lock_ff;
        key_ok = ~dir_lock_ff | relock_ff;
        c_pull = ext_ok & rise.pull;
        c_emerg = ext_ok & rise.emerg & fire;
        c_smoke = rise.smoke_trip & ~dir_lock_ff;
        c_step = ext_ok & rise.step;
        c_open = (key_ok & rise.key_open) | (ext_ok & rise.open_in) | c_pull;
        c_close = (key_ok & rise.key_close) | (ext_ok & rise.close_in);
        c_stop = (key_ok & rise.key_stop) | (ext_ok & ~pn.stop_nc);
        c_move = c_open | c_close | c_step | c_emerg | c_smoke;
        safe_close = pn.upper_nc & pn.lower_nc;
        case (tgt_ff)
            GCIN_TGT_MID1: reached = pl.at_mid1;
            GCIN_TGT_SMOKE: reached = pl.at_smoke;
            default: reached = pl.at_open;
        endcase

        nxt_st = st_ff;
        nxt_tgt = tgt_ff;
        nxt_tmr = (sec_tick && tmr_ff != 8'hff) ? tmr_ff + 8'h1 : tmr_ff;
        nxt_wait = (sec_tick && wait_ff != 8'h0) ? wait_ff - 8'h1 : wait_ff;
        nxt_last_up = last_up_ff;
        nxt_aclose = aclose_ff;
        nxt_tout = tout_ff & ~c_move;
        nxt_relock = relock_ff | (dir_lock_ff & pp.key_locked & ~pn.key_locked);
        nxt_dir_lock = dir_lock_ff;
        if (dir_lock_ff && relock_ff && (rise.key_open || rise.key_close)) begin
            nxt_dir_lock = 1'b0;
            nxt_relock = 1'b0;
        end
        nxt_nvm = nvm_ff & ~restart;
        nxt_smoke_alarm = smoke_alarm_ff & ~(rise.lock_in & smoke_alarm_ff);

        if (c_stop) begin
            nxt_st = GCIN_ST_STOP;
            nxt_aclose = 1'b0;
        end else if (c_emerg || c_smoke || c_open) begin
            nxt_st = GCIN_ST_UP;
            nxt_tmr = 8'h0;
            nxt_aclose = c_emerg;
            nxt_tgt = c_emerg ? GCIN_TGT_MID1 : c_smoke ? GCIN_TGT_SMOKE : GCIN_TGT_OPEN;
            nxt_wait = c_emerg ? emerg_ff : c_smoke ? smoke_ff : hold_ff;
        end else if (c_close) begin
            nxt_st = GCIN_ST_DOWN;
            nxt_tmr = 8'h0;
        end else if (c_step) begin
            nxt_tmr = 8'h0;
            nxt_tgt = GCIN_TGT_OPEN;
            if (st_ff == GCIN_ST_UP || st_ff == GCIN_ST_DOWN) begin
                nxt_st = GCIN_ST_STOP;
            end else if (last_up_ff) begin
                nxt_st = GCIN_ST_DOWN;
            end else begin
                nxt_st = GCIN_ST_UP;
            end
        end else begin
            case (st_ff)
                GCIN_ST_UP: begin
                    nxt_last_up = 1'b1;
                    if (reached) begin
                        // Pull, emergency and smoke openings close again later
                        nxt_st = (c_pull_pend_ff) ? GCIN_ST_WAIT : GCIN_ST_STOP;
                        // Hold time runs from arrival, not from the command
                        nxt_wait = (tgt_ff == GCIN_TGT_MID1) ? emerg_ff :
                            (tgt_ff == GCIN_TGT_SMOKE) ? smoke_ff : hold_ff;
                    end
                end
                GCIN_ST_DOWN: begin
                    nxt_last_up = 1'b0;
                    if (pl.at_closed) begin
                        nxt_st = GCIN_ST_STOP;
                        nxt_aclose = 1'b0;
                    end else if (!safe_close && !aclose_ff) begin
                        nxt_st = GCIN_ST_STOP;
                    end
                end
                GCIN_ST_WAIT: begin
                    if (wait_ff == 8'h0 && (safe_close || aclose_ff)) begin
                        nxt_st = GCIN_ST_DOWN;
                        nxt_tmr = 8'h0;
                    end
                end
                default: nxt_st = GCIN_ST_STOP;
            endcase
        end

        // No closing start while a sensor is tripped, except alarm closing
        if (nxt_st == GCIN_ST_DOWN && !safe_close && !nxt_aclose) begin
            nxt_st = GCIN_ST_STOP;
        end
        if ((st_ff == GCIN_ST_UP || st_ff == GCIN_ST_DOWN) && tmr_ff >= `GCIN_TRAVEL_S
            && nxt_st != GCIN_ST_STOP) begin
            nxt_st = GCIN_ST_STOP;
            nxt_tout = 1'b1;
        end
        if (pl.dir_wrong) begin
            nxt_st = GCIN_ST_STOP;
            nxt_dir_lock = 1'b1;
            nxt_relock = 1'b0;
        end
        if (restart) begin
            nxt_st = GCIN_ST_STOP;
            // A timeout raised in this very cycle survives the restart
            nxt_tout = nxt_tout & ~tout_ff;
            nxt_aclose = 1'b0;
            if (!pl.dir_wrong) begin
                nxt_dir_lock = 1'b0;
            end
        end
        if (pl.nvm_bad) begin
            nxt_nvm = 1'b1;
        end
        if (rise.smoke_trip) begin
            nxt_smoke_alarm = 1'b1;
        end
    end

    // Remembers that the current opening is one that closes by itself
    logic nxt_pull_pend;
    always_comb begin
        nxt_pull_pend = c_pull_pend_ff;
        if (c_pull || c_emerg || c_smoke) begin
            nxt_pull_pend = 1'b1;
        end else if (c_open || c_close || c_step || c_stop || restart) begin
            nxt_pull_pend = 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            st_ff <= GCIN_ST_STOP;
            tgt_ff <= GCIN_TGT_OPEN;
            tmr_ff <= '0;
            wait_ff <= '0;
            last_up_ff <= 1'b0;
            aclose_ff <= 1'b0;
            tout_ff <= 1'b0;
            dir_lock_ff <= 1'b0;
            relock_ff <= 1'b0;
            nvm_ff <= 1'b0;
            smoke_alarm_ff <= 1'b0;
            c_pull_pend_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            tgt_ff <= nxt_tgt;
            tmr_ff <= nxt_tmr;
            wait_ff <= nxt_wait;
            last_up_ff <= nxt_last_up;
            aclose_ff <= nxt_aclose;
            tout_ff <= nxt_tout;
            dir_lock_ff <= nxt_dir_lock;
            relock_ff <= nxt_relock;
            nvm_ff <= nxt_nvm;
            smoke_alarm_ff <= nxt_smoke_alarm;
            c_pull_pend_ff <= nxt_pull_pend;
        end
    end

    // Fault code shown on the display, highest priority first
    always_comb begin
        if (!pl.link_ok) begin
            fault = GCIN_FC_ENCODER_LINK;
        end else if (!pl.csum_ok) begin
            fault = GCIN_FC_ENCODER_CHECKSUM;
        end else if (dir_lock_ff) begin
            fault = GCIN_FC_DIRECTION;
        end else if (nvm_ff) begin
            fault = GCIN_FC_NONVOLATILE_MEMORY;
        end else if (pl.safety_passed) begin
            fault = GCIN_FC_SAFETY_END_POSITION;
        end else if (pl.calib_bad) begin
            fault = GCIN_FC_CALIBRATION;
        end else if (tout_ff) begin
            fault = GCIN_FC_TRAVEL_TIMEOUT;
        end else begin
            fault = GCIN_FC_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Safety sensor flash-count sequencer
    logic lower_cond, upper_cond, ose_cond;
    logic grp_ff, nxt_grp, on_ff, nxt_on;
    logic [1:0] left_ff, nxt_left, gap_ff, nxt_gap;

    always_comb begin
        lower_cond = (pn.lower_present & ~pn.lower_nc) | (~pn.lower_present & ~dip_ff[1]);
        upper_cond = (pn.upper_present & ~pn.upper_nc) | (~pn.upper_present & ~dip_ff[2]);
        ose_cond = (pn.ose_trip | ~pn.ose_present) & dip_ff[8];
        nxt_grp = grp_ff;
        nxt_on = on_ff;
        nxt_left = left_ff;
        nxt_gap = gap_ff;
        if (blk_tick) begin
            if (left_ff == 2'h0) begin
                if (gap_ff != 2'h0) begin
                    nxt_gap = gap_ff - 2'h1;
                end else if ((grp_ff ? lower_cond : upper_cond)) begin
                    nxt_grp = ~grp_ff;
                    nxt_left = grp_ff ? 2'h1 : 2'h2;
                    nxt_on = 1'b1;
                end else if ((grp_ff ? upper_cond : lower_cond)) begin
                    nxt_left = grp_ff ? 2'h2 : 2'h1;
                    nxt_on = 1'b1;
                end
            end else if (on_ff) begin
                nxt_on = 1'b0;
                nxt_left = left_ff - 2'h1;
                if (left_ff == 2'h1) begin
                    nxt_gap = `GCIN_PAUSE_PHASES;
                end
            end else begin
                nxt_on = 1'b1;
            end
        end
    end

    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            grp_ff <= 1'b1;
            on_ff <= 1'b0;
            left_ff <= '0;
            gap_ff <= '0;
        end else begin
            grp_ff <= nxt_grp;
            on_ff <= nxt_on;
            left_ff <= nxt_left;
            gap_ff <= nxt_gap;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs
    gcin_out_s out_ff, nxt_out;
    logic moving;

    always_comb begin
        moving = (st_ff == GCIN_ST_UP) || (st_ff == GCIN_ST_DOWN);
        nxt_out.motor_up = (st_ff == GCIN_ST_UP);
        nxt_out.motor_down = (st_ff == GCIN_ST_DOWN);
        nxt_out.alarm_close = aclose_ff & (st_ff == GCIN_ST_DOWN);
        nxt_out.fault = fault;
        nxt_out.rel_mains = pl.mains_ok;
        nxt_out.rel_batt = pl.batt_ok;
        nxt_out.rel_safe_end = pl.safe_end_disc;
        nxt_out.rel_brake = pl.brake_act;
        nxt_out.rel_mid1 = pl.at_mid1;
        nxt_out.rel_open = pl.at_open;
        nxt_out.rel_closed = pl.at_closed;
        nxt_out.led_active = moving ? blink_ff : enable_ff;
        nxt_out.led_ose = ose_cond & blink_ff;
        nxt_out.led_safety = on_ff;
    end

    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            out_ff <= '0;
        end else begin
            out_ff <= nxt_out;
        end
    end

    assign OUTS = out_ff;

endmodule

// [design/gcin_consts.svh]
/*
 * Offsets, field positions, reset values and timing figures of the gate
 * control block. Assumes a 100 MHz CORE_CLK.
 */
`ifndef GCIN_CONSTS_SVH
`define GCIN_CONSTS_SVH

// Register byte offsets
`define GCIN_REG_HOLD 8'h00
`define GCIN_REG_EMERG 8'h04
`define GCIN_REG_SMOKE 8'h08
`define GCIN_REG_CTRL 8'h0c
`define GCIN_REG_STATUS 8'h10

// Reset values, seconds except the control enable bit
`define GCIN_HOLD_RST 8'h0a
`define GCIN_EMERG_RST 8'h0a
`define GCIN_SMOKE_RST 8'h0a
`define GCIN_CTRL_RST 1'b1

// Field positions
`define GCIN_CTRL_ENABLE 0
`define GCIN_ST_FAULT_LSB 0
`define GCIN_ST_STATE_LSB 4
`define GCIN_ST_DIRLOCK 8
`define GCIN_ST_SMOKEALM 9

// Timing
`define GCIN_CLK_PERIOD_NS 10
`define GCIN_SEC_NS 1000000000
`define GCIN_BLINK_NS 250000000
`define GCIN_TRAVEL_S 8'd60
`define GCIN_PAUSE_PHASES 2'd3

`endif

// [design/gcin_pkg.sv]
/*
 * Types of the gate control block.
 * Assumes gcin_consts.svh for the numeric constants.
 */
package gcin_pkg;

    typedef enum logic [3:0] {
        GCIN_ST_STOP = 4'b0001,
        GCIN_ST_UP = 4'b0010,
        GCIN_ST_DOWN = 4'b0100,
        GCIN_ST_WAIT = 4'b1000
    } gcin_state_e;

    typedef enum logic [1:0] {
        GCIN_TGT_OPEN = 2'h0,
        GCIN_TGT_MID1 = 2'h1,
        GCIN_TGT_SMOKE = 2'h2
    } gcin_target_e;

    typedef enum logic [2:0] {
        GCIN_FC_NONE = 3'h0,
        GCIN_FC_ENCODER_LINK = 3'h1,
        GCIN_FC_TRAVEL_TIMEOUT = 3'h2,
        GCIN_FC_DIRECTION = 3'h3,
        GCIN_FC_NONVOLATILE_MEMORY = 3'h4,
        GCIN_FC_ENCODER_CHECKSUM = 3'h5,
        GCIN_FC_SAFETY_END_POSITION = 3'h6,
        GCIN_FC_CALIBRATION = 3'h7
    } gcin_fault_e;

    // Pin inputs, high = contact tied to the common +24 V terminal
    typedef struct packed {
        logic step;
        logic pull;
        logic emerg;
        logic open_in;
        logic close_in;
        logic stop_nc;
        logic upper_nc;
        logic lower_nc;
        logic upper_present;
        logic lower_present;
        logic ose_trip;
        logic ose_present;
        logic reset_in;
        logic lock_in;
        logic fire_alarm_nc;
        logic smoke_trip;
        logic key_open;
        logic key_close;
        logic key_stop;
        logic key_locked;
    } gcin_pins_s;

    // Status coming from the encoder and the power section
    typedef struct packed {
        logic link_ok;
        logic csum_ok;
        logic safety_passed;
        logic dir_wrong;
        logic nvm_bad;
        logic calib_bad;
        logic at_open;
        logic at_mid1;
        logic at_smoke;
        logic at_closed;
        logic mains_ok;
        logic batt_ok;
        logic safe_end_disc;
        logic brake_act;
    } gcin_plant_s;

    typedef struct packed {
        logic motor_up;
        logic motor_down;
        logic alarm_close;
        logic [2:0] fault;
        logic rel_mains;
        logic rel_batt;
        logic rel_safe_end;
        logic rel_brake;
        logic rel_mid1;
        logic rel_open;
        logic rel_closed;
        logic led_active;
        logic led_ose;
        logic led_safety;
    } gcin_out_s;

endpackage

// [dv/gcin_checker.sv]
/* Port assertions for gcin_top.
   Assumes pin and plant changes reach the outputs within four edges. */
`timescale 1ns/1ns
module gcin_checker
    import gcin_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_ACK_O,
    input wire gcin_pkg::gcin_pins_s PINS,
    input wire gcin_pkg::gcin_plant_s PLANT,
    input wire gcin_pkg::gcin_out_s OUTS
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);
    a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held two cycles");
    a_ack_answer: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("request not acked");
    a_link_code: assert property (
        !PLANT.link_ok [*7] |-> OUTS.fault == GCIN_FC_ENCODER_LINK)
        else $error("link fault code missing");
    a_csum_code: assert property (
        (PLANT.link_ok && !PLANT.csum_ok) [*7] |-> OUTS.fault == GCIN_FC_ENCODER_CHECKSUM)
        else $error("checksum fault code missing");
    a_mains_relay: assert property (
        $stable(PLANT.mains_ok) [*7] |-> OUTS.rel_mains == PLANT.mains_ok)
        else $error("mains relay wrong");
    a_open_relay: assert property (
        $stable(PLANT.at_open) [*7] |-> OUTS.rel_open == PLANT.at_open)
        else $error("open relay wrong");
    a_upper_stop: assert property (
        (!PINS.upper_nc && PINS.fire_alarm_nc) [*7] |-> !OUTS.motor_down)
        else $error("closing despite upper sensor");
    a_motor_excl: assert property (!(OUTS.motor_up && OUTS.motor_down))
        else $error("both motor directions");
    c_ack: cover property (WB_ACK_O);
    c_down: cover property (OUTS.motor_down);
    c_led: cover property (OUTS.led_safety);
endmodule
bind gcin_top gcin_checker u_gcin_checker (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST),
    .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .PINS(PINS),
    .PLANT(PLANT), .OUTS(OUTS));

// [dv/gcin_plant_model.sv]
/* Gate and encoder model: position follows the motor outputs.
   Assumes the bench supplies the fault and power levels on base. */
`timescale 1ns/1ns
module gcin_plant_model
    import gcin_pkg::*;
#(
    parameter int TRAVEL = 30
) (
    input wire logic clk,
    input wire logic rst,
    input wire gcin_pkg::gcin_out_s outs,
    input wire logic [13:0] base,
    output gcin_pkg::gcin_plant_s plant
);
    int pos;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pos <= 0;
        end else if (outs.motor_up && pos < TRAVEL) begin
            pos <= pos + 1;
        end else if (outs.motor_down && pos > 0) begin
            pos <= pos - 1;
        end
    end
    // Levels are high when active, as seen at the +24 V side
    always_comb begin
        plant = base;
        plant.at_open = (pos == TRAVEL);
        plant.at_mid1 = (pos == TRAVEL / 2);
        plant.at_smoke = (pos == TRAVEL / 2);
        plant.at_closed = (pos == 0);
    end
endmodule

// [dv/gcin_top_tb.sv]
/* Self-checking bench for gcin_top.
   Assumes gcin_checker is bound and the plant model closes the loop. */
`timescale 1ns/1ns
`include "gcin_consts.svh"
module gcin_top_tb;
    import gcin_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic ack;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0;
    logic [31:0] rd;
    logic [31:0] q;
    logic [13:0] base = 14'h300c;
    gcin_pins_s pins = 20'h07d20;
    gcin_plant_s plant;
    gcin_out_s outs;
    int failures = 0;
    int checks = 0;
    int i;
    always #5 clk = ~clk;
    gcin_top #(.SEC_CYCLES(20), .BLINK_CYCLES(4)) u_gcin_top (.CORE_CLK(clk), .SYS_RST(rst),
        .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_DAT_I(wd),
        .WB_SEL_I(4'hf), .WB_DAT_O(rd), .WB_ACK_O(ack), .PINS(pins), .PLANT(plant),
        .DIP(8'h80), .OUTS(outs));
    gcin_plant_model u_gcin_plant_model (.clk(clk), .rst(rst), .outs(outs), .base(base),
        .plant(plant));
    ////////////////////////////////////////////////////////////////////////////////////
    task print_verdict;
        if (failures == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task lim(input int k);
        if (k >= 400) begin
            chk("wait", 0, 1);
            print_verdict();
        end
    endtask
    task settle(input int n);
        repeat (n) @(negedge clk);
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        @(posedge clk);
        for (i = 0; i < 400 && ack !== 1'b1; i++) @(posedge clk);
        q = rd;
        lim(i);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    // Toggles the masked pins for three cycles; NC pins therefore trip low
    task pulse(input logic [19:0] m);
        @(posedge clk);
        pins <= pins ^ m;
        repeat (3) @(posedge clk);
        pins <= pins ^ m;
    endtask
    task wait_out(input int b);
        for (i = 0; i < 400 && outs[b] !== 1'b1; i++) @(negedge clk);
        lim(i);
    endtask
    task t_regs;
        wb(1'b0, `GCIN_REG_HOLD, 32'h0);
        chk("hold", q, {24'h0, `GCIN_HOLD_RST});
        wb(1'b1, 8'h40, 32'hff);
        wb(1'b0, 8'h40, 32'h0);
        chk("unmapped", q, 32'h0);
        wb(1'b1, `GCIN_REG_HOLD, 32'h2);
        wb(1'b0, `GCIN_REG_HOLD, 32'h0);
        chk("hold", q, 32'h2);
    endtask
    task t_faults;
        logic [13:0] m [4] = '{14'h2000, 14'h1000, 14'h0800, 14'h0100};
        gcin_fault_e c [4] = '{GCIN_FC_ENCODER_LINK, GCIN_FC_ENCODER_CHECKSUM,
            GCIN_FC_SAFETY_END_POSITION, GCIN_FC_CALIBRATION};
        for (int k = 0; k < 5; k++) begin
            @(posedge clk);
            base <= base ^ (k < 4 ? m[k] : 14'h0200);
            settle(8);
            chk("fault", outs.fault, k < 4 ? c[k] : GCIN_FC_NONVOLATILE_MEMORY);
            @(posedge clk);
            base <= base ^ (k < 4 ? m[k] : 14'h0200);
        end
        settle(8);
        chk("nvm latch", outs.fault, GCIN_FC_NONVOLATILE_MEMORY);
        @(posedge clk);
        base <= base ^ 14'h0400;
        settle(8);
        @(posedge clk);
        base <= base ^ 14'h0400;
        settle(8);
        chk("dir latch", outs.fault, GCIN_FC_DIRECTION);
        pulse(20'h00080);
        settle(8);
        chk("restart", outs.fault, GCIN_FC_NONE);
    endtask
    task t_relays;
        for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            base[3:0] <= k == 0 ? 4'ha : k == 1 ? 4'h5 : 4'hc;
            settle(8);
            chk("relays", {outs.rel_mains, outs.rel_batt, outs.rel_safe_end, outs.rel_brake},
                k == 0 ? 4'ha : k == 1 ? 4'h5 : 4'hc);
        end
    endtask
    task t_led;
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            pins <= pins ^ (k == 0 ? 20'h01000 : 20'h00200);
            wait_out(k);
            @(posedge clk);
            pins <= pins ^ (k == 0 ? 20'h01000 : 20'h00200);
            settle(40);
            chk("led quiet", outs[1:0], 2'h0);
        end
    endtask
    task t_move;
        chk("active", outs.led_active, 1'b1);
        pulse(20'h40000);
        wait_out(4);
        wait_out(14);
        chk("hold time", i >= 18, 1'b1);
        @(posedge clk);
        pins <= pins ^ 20'h02000;
        settle(8);
        chk("upper stop", outs.motor_down, 1'b0);
        pulse(20'h80000);
        wait_out(15);
        pulse(20'h80000);
        settle(8);
        chk("step stop", outs.motor_up, 1'b0);
        @(posedge clk);
        pins <= pins ^ 20'h02000;
        pulse(20'h80000);
        wait_out(3);
    endtask
    task t_smoke;
        pulse(20'h00010);
        wait_out(5);
        wait_out(3);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_relays();
        t_faults();
        t_led();
        t_move();
        t_smoke();
        print_verdict();
    end
endmodule
